// File: tsrs_pkg.sv
// Package of constants and types for the three stage reset sequencer.
package tsrs_pkg;

    // ------------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_MHZ         = 250;
    localparam int unsigned CYC_PER_US      = CLK_MHZ;
    // Base tick of the shared counter chain, in microseconds.
    localparam int unsigned TICK_US         = 1;
    localparam int unsigned TICK_CYC        = TICK_US * CYC_PER_US;
    // Stage one active time per delay setting, in milliseconds.
    localparam int unsigned STAGE1_GND_MS   = 15;
    localparam int unsigned STAGE1_OPEN_MS  = 30;
    localparam int unsigned STAGE1_HIGH_MS  = 75;
    // Button debounce delay, in microseconds (window 1000 to 2000).
    localparam int unsigned DEBOUNCE_US     = 1500;
    // Supply glitch filter, in microseconds; dips this short are ignored.
    localparam int unsigned SUPPLY_FILT_US  = 2000;
    // Stage ratios against stage one.
    localparam int unsigned STAGE2_RATIO    = 5;
    localparam int unsigned STAGE3_RATIO    = 10;

    // ------------------------------------------------------------------
    // Three level select codes
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        TSRS_SEL_LOW,
        TSRS_SEL_HIGH,
        TSRS_SEL_OPEN
    } tsrs_sel_t;

    // Tolerance choices.
    typedef enum logic [1:0] {
        TSRS_TOL_5,
        TSRS_TOL_10,
        TSRS_TOL_WIDE
    } tsrs_tol_t;

endpackage : tsrs_pkg

// File: tsrs_filter.sv
// Stability filter that passes a level only after it holds for a set time.
`timescale 1ns/1ps
module tsrs_filter
    import tsrs_pkg::*;
#(
    parameter int unsigned HOLD_TICKS = 1500,
    parameter bit          RST_VAL    = 1'b1
) (
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic tick,
    input  wire logic din,
    output logic      dout
);

    localparam int unsigned CW = $clog2(HOLD_TICKS + 1);

    logic [CW-1:0] cnt_q;

    // Count ticks while the input differs from the output; adopt it at the hold time.
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_q <= '0;
            dout  <= RST_VAL;
        end else if (din == dout) begin
            cnt_q <= '0;
        end else if (tick) begin
            if (cnt_q == CW'(HOLD_TICKS - 1)) begin
                dout  <= din;
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

endmodule : tsrs_filter

// File: tsrs_sequencer.sv
// Three stage reset sequencer with supply fault, button and select inputs.
`timescale 1ns/1ps
module tsrs_sequencer
    import tsrs_pkg::*;
#(
    parameter int unsigned TICK_CYCLES    = TICK_CYC,
    parameter int unsigned DEBOUNCE_TICKS = DEBOUNCE_US / TICK_US,
    parameter int unsigned SUPPLY_TICKS   = SUPPLY_FILT_US / TICK_US,
    parameter int unsigned MS_TICKS       = 1000 / TICK_US
) (
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       supply_ok,
    input  wire logic       supply_above_min,
    input  wire logic       manual_reset_n,
    input  wire logic [1:0] delay_select,
    input  wire logic [1:0] tolerance_select,
    output logic [1:0]      tol_code_q,
    output logic            reset_stage1_n,
    output logic            reset_stage2_n,
    output logic            reset_stage3_n
);

    // ------------------------------------------------------------------
    // Shared time base
    // ------------------------------------------------------------------
    localparam int unsigned TW = $clog2(TICK_CYCLES);
    localparam int unsigned S3_MAX = STAGE1_HIGH_MS * MS_TICKS * STAGE3_RATIO;
    localparam int unsigned SW = $clog2(S3_MAX + 1);

    typedef enum logic [1:0] {
        TSRS_ST_HOLD,
        TSRS_ST_REL1,
        TSRS_ST_REL2,
        TSRS_ST_DONE
    } tsrs_state_t;

    logic [TW-1:0] div_q;
    logic          tick_q;
    logic          supply_good;
    logic          button_n;
    logic          cause;
    logic [1:0]    td_code_q;
    logic [SW-1:0] elapsed_q;
    logic [SW-1:0] stage1_len;
    tsrs_state_t   state_q;

    // Map a raw select pin code to a setting; codes 2 and 3 count as open.
    function automatic tsrs_sel_t sel_decode(input logic [1:0] raw);
        if (raw == 2'h0) begin
            sel_decode = TSRS_SEL_LOW;
        end else if (raw == 2'h1) begin
            sel_decode = TSRS_SEL_HIGH;
        end else begin
            sel_decode = TSRS_SEL_OPEN;
        end
    endfunction : sel_decode

    // Divider making the one tick pulse that times every delay.
    always_ff @(posedge mclk) begin
        if (rst) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else if (div_q == TW'(TICK_CYCLES - 1)) begin
            div_q  <= '0;
            tick_q <= 1'b1;
        end else begin
            div_q  <= div_q + 1'b1;
            tick_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Input conditioning
    // ------------------------------------------------------------------
    // Supply filter: a fault must persist past the glitch window.
    // One extra tick, so that a dip lasting exactly the window is still ignored.
    tsrs_filter #(
        .HOLD_TICKS (SUPPLY_TICKS + 1),
        .RST_VAL    (1'b0)
    ) u_supply_filt (
        .mclk (mclk),
        .rst  (rst),
        .tick (tick_q),
        .din  (supply_ok),
        .dout (supply_good)
    );

    // Button debounce filter.
    tsrs_filter #(
        .HOLD_TICKS (DEBOUNCE_TICKS),
        .RST_VAL    (1'b1)
    ) u_button_filt (
        .mclk (mclk),
        .rst  (rst),
        .tick (tick_q),
        .din  (manual_reset_n),
        .dout (button_n)
    );

    assign cause = !supply_good || !button_n;

    // Select latches: tolerance only while below the lowest trip level.
    always_ff @(posedge mclk) begin
        if (rst) begin
            tol_code_q <= TSRS_TOL_5;
            td_code_q  <= TSRS_SEL_LOW;
        end else begin
            if (!supply_above_min) begin
                case (sel_decode(tolerance_select))
                    TSRS_SEL_HIGH: tol_code_q <= TSRS_TOL_5;
                    TSRS_SEL_LOW:  tol_code_q <= TSRS_TOL_10;
                    default:       tol_code_q <= TSRS_TOL_WIDE;
                endcase
            end
            if (state_q == TSRS_ST_HOLD) begin
                td_code_q <= sel_decode(delay_select);
            end
        end
    end

    // Stage one length in ticks for the held delay setting.
    always_comb begin
        case (td_code_q)
            TSRS_SEL_HIGH: stage1_len = SW'(STAGE1_HIGH_MS * MS_TICKS);
            TSRS_SEL_OPEN: stage1_len = SW'(STAGE1_OPEN_MS * MS_TICKS);
            default:       stage1_len = SW'(STAGE1_GND_MS * MS_TICKS);
        endcase
    end

    // ------------------------------------------------------------------
    // Release sequencer
    // ------------------------------------------------------------------
    // Any cause returns to hold and restarts the count; ticks advance stages.
    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q   <= TSRS_ST_HOLD;
            elapsed_q <= '0;
        end else if (cause) begin
            state_q   <= TSRS_ST_HOLD;
            elapsed_q <= '0;
        end else if (state_q != TSRS_ST_DONE && tick_q) begin
            elapsed_q <= elapsed_q + 1'b1;
            case (state_q)
                TSRS_ST_HOLD: begin
                    if (elapsed_q == stage1_len - 1'b1) state_q <= TSRS_ST_REL1;
                end
                TSRS_ST_REL1: begin
                    if (elapsed_q == SW'(stage1_len * STAGE2_RATIO) - 1'b1)
                        state_q <= TSRS_ST_REL2;
                end
                TSRS_ST_REL2: begin
                    if (elapsed_q == SW'(stage1_len * STAGE3_RATIO) - 1'b1)
                        state_q <= TSRS_ST_DONE;
                end
                default: state_q <= TSRS_ST_DONE;
            endcase
        end
    end

    // Outputs registered from the state; all low in hold.
    always_ff @(posedge mclk) begin
        if (rst || cause) begin
            reset_stage1_n <= 1'b0;
            reset_stage2_n <= 1'b0;
            reset_stage3_n <= 1'b0;
        end else begin
            reset_stage1_n <= state_q != TSRS_ST_HOLD;
            reset_stage2_n <= state_q == TSRS_ST_REL2 || state_q == TSRS_ST_DONE;
            reset_stage3_n <= state_q == TSRS_ST_DONE;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_order_two_one: assert property (@(posedge mclk) disable iff (rst)
        reset_stage2_n |-> reset_stage1_n) else $error("Stage two released before one.");
    chk_order_three_two: assert property (@(posedge mclk) disable iff (rst)
        reset_stage3_n |-> reset_stage2_n) else $error("Stage three released early.");
    chk_fault_forces_low: assert property (@(posedge mclk) disable iff (rst)
        !supply_good |=> !reset_stage1_n && !reset_stage2_n && !reset_stage3_n)
        else $error("Supply fault did not force resets.");
    chk_button_held_low: assert property (@(posedge mclk) disable iff (rst)
        !button_n |=> !reset_stage3_n) else $error("Held button left reset released.");
    chk_released_stays: assert property (@(posedge mclk) disable iff (rst)
        reset_stage3_n && !cause |=> reset_stage3_n) else $error("Reset dropped without cause.");
    chk_tol_frozen: assert property (@(posedge mclk) disable iff (rst)
        $past(supply_above_min) |-> $stable(tol_code_q)) else $error("Tolerance changed above trip.");
    chk_stage1_release: assert property (@(posedge mclk) disable iff (rst)
        $rose(reset_stage1_n) |-> $past(elapsed_q, 2) == stage1_len - 1'b1)
        else $error("Stage one released at wrong count.");
    chk_td_held: assert property (@(posedge mclk) disable iff (rst)
        state_q != TSRS_ST_HOLD |=> $stable(td_code_q)) else $error("Delay select changed mid run.");

endmodule : tsrs_sequencer

// File: tsrs_button.sv
// Pushbutton model with pull-up for the manual reset input.
`timescale 1ns/1ps
module tsrs_button (
    input  wire logic mclk,
    output logic      manual_reset_n
);
    // The pull-up holds the released line high.
    initial manual_reset_n = 1'b1;

    // Holds the button down for n cycles, changed just after an edge.
    task automatic press(input int n);
        @(posedge mclk);
        manual_reset_n <= 1'b0;
        repeat (n) @(posedge mclk);
        manual_reset_n <= 1'b1;
    endtask : press
endmodule : tsrs_button

// File: test_tsrs_sequencer.sv
// Self-checking bench for the three stage reset sequencer.
`timescale 1ns/1ps
module test_tsrs_sequencer;
    import tsrs_pkg::*;
    localparam int MS = 40;
    localparam int SL = 96;
    logic       mclk = 1'b0;
    logic       rst = 1'b1;
    logic       supply_ok = 1'b0;
    logic       supply_above_min = 1'b0;
    logic [1:0] delay_select = 2'h0;
    logic [1:0] tolerance_select = 2'h0;
    logic [1:0] t;
    wire        manual_reset_n;
    wire [1:0]  tol_code_q;
    wire [2:0]  rs;
    logic [2:0] pv = 3'h0;
    logic [2:0] ev[$];
    int         lo[$];
    int         hi[$];
    int         fails = 0;
    int         n_checks = 0;
    int         cyc = 0;
    int         mnv[3] = '{10, 20, 50};
    logic [1:0] dv[3] = '{2'h0, 2'h2, 2'h1};

    tsrs_sequencer #(.TICK_CYCLES(4), .DEBOUNCE_TICKS(15), .SUPPLY_TICKS(20), .MS_TICKS(10))
    i_tsrs_sequencer (.mclk(mclk), .rst(rst), .supply_ok(supply_ok),
        .supply_above_min(supply_above_min), .manual_reset_n(manual_reset_n),
        .delay_select(delay_select), .tolerance_select(tolerance_select),
        .tol_code_q(tol_code_q), .reset_stage1_n(rs[0]), .reset_stage2_n(rs[1]),
        .reset_stage3_n(rs[2]));
    tsrs_button i_tsrs_button (.mclk(mclk), .manual_reset_n(manual_reset_n));

    // Free running clock at 4 ns.
    initial forever #2 mclk = ~mclk;

    task automatic results;
        if (fails == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    task automatic note(input logic [2:0] v, input int a, input int b);
        ev.push_back(v);
        lo.push_back(a);
        hi.push_back(b);
    endtask : note

    // Notes the staged release that starts at t0 for a stage one minimum of mn ms.
    task automatic stages(input int mn, input int t0);
        note(3'h1, t0 + mn * MS, t0 + 2 * mn * MS + SL);
        note(3'h3, t0 + 5 * mn * MS, t0 + 10 * mn * MS + SL);
        note(3'h7, t0 + 10 * mn * MS, t0 + 20 * mn * MS + SL);
    endtask : stages

    // Waits until every noted change has been seen, no later than its window.
    task automatic drain;
        while (ev.size() > 0) begin
            @(posedge mclk);
            if (ev.size() > 0 && cyc > hi[0]) begin
                $display("unexpected %0t: output change missing", $time);
                fails++;
                results;
            end
        end
    endtask : drain

    task automatic chk_tol(input logic [1:0] s);
        n_checks++;
        if (tol_code_q !== ((s == 2'h1) ? 2'h0 : (s == 2'h0) ? 2'h1 : 2'h2)) begin
            $display("unexpected %0t: tolerance code", $time);
            fails++;
        end
    endtask : chk_tol

    // Compares each output change with the oldest note.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (!rst && rs !== pv) begin
            n_checks++;
            if (ev.size() == 0) begin
                $display("unexpected %0t: stray output change", $time);
                fails++;
            end else begin
                if (rs !== ev[0] || cyc < lo[0] || cyc > hi[0]) begin
                    $display("unexpected %0t: output change", $time);
                    fails++;
                end
                void'(ev.pop_front());
                void'(lo.pop_front());
                void'(hi.pop_front());
            end
        end
        pv <= rs;
    end

    // Main sequence: tolerance latch, supply cycles per delay, button.
    initial begin
        void'($urandom(93));
        repeat (10) @(posedge mclk);
        rst <= 1'b0;
        for (int k = 0; k < 4; k++) begin
            t = 2'(k);
            supply_above_min <= 1'b0;
            supply_ok <= 1'b0;
            tolerance_select <= t;
            repeat (8) @(posedge mclk);
            chk_tol(t);
            supply_above_min <= 1'b1;
            // Short supply blips while above the minimum must not reach the outputs.
            supply_ok <= 1'($urandom_range(1));
            tolerance_select <= 2'($urandom_range(3));
            repeat (8) @(posedge mclk);
            chk_tol(t);
        end
        supply_ok <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            // The open setting is driven as either of its two codes.
            delay_select <= (k == 1) ? 2'($urandom_range(3, 2)) : dv[k];
            repeat (4) @(posedge mclk);
            supply_ok <= 1'b1;
            stages(mnv[k], cyc);
            drain;
            supply_ok <= 1'b0;
            repeat ($urandom_range(80, 20)) @(posedge mclk);
            supply_ok <= 1'b1;
            repeat (150) @(posedge mclk);
            supply_ok <= 1'b0;
            // The fault may or may not take the supply below the lowest trip.
            supply_above_min <= 1'($urandom_range(1));
            note(3'h0, cyc + 81, cyc + SL + 8);
            drain;
            if (!supply_above_min) begin
                chk_tol(tolerance_select);
            end
            supply_above_min <= 1'b1;
        end
        delay_select <= 2'h0;
        supply_ok <= 1'b1;
        stages(10, cyc);
        drain;
        i_tsrs_button.press(20);
        repeat (150) @(posedge mclk);
        note(3'h0, cyc + 40, cyc + 90);
        stages(10, cyc + 200);
        i_tsrs_button.press(200);
        drain;
        results;
    end
endmodule : test_tsrs_sequencer
